/* mdm_decoder_model.sv */
`default_nettype none
// Stand-in for the decoder and register file: raises one request at a time,
// counts clocks to the answer and keeps what the unit writes back
module mdm_decoder_model (
  // Clock
  input  wire logic        clock_i,
  // Request towards the unit, operands come straight from the register file
  output logic             start_o,
  output logic [2:0]       op_o,
  output logic             ram_fetch_o,
  output logic [15:0]      first_pair_o,
  output logic [15:0]      second_pair_o,
  output logic [15:0]      divisor_pair_o,
  output logic [31:0]      wide_product_pair_o,
  output logic [31:0]      wide_divisor_pair_o,
  // Answer and write-back from the unit
  input  wire logic        done_i,
  input  wire logic        first_pair_we_i,
  input  wire logic [15:0] first_pair_i,
  input  wire logic        divisor_pair_we_i,
  input  wire logic [15:0] divisor_pair_i,
  input  wire logic        wide_product_pair_we_i,
  input  wire logic [31:0] wide_product_pair_i,
  input  wire logic        wide_divisor_pair_we_i,
  input  wire logic [31:0] wide_divisor_pair_i
);
  timeunit 1ns;
  timeprecision 100ps;

  int n_writes = 0; // Cycles in which any pair was written back

  // Every request line has a value from time zero
  initial begin
    start_o = 1'b0;
    op_o = 3'h0;
    ram_fetch_o = 1'b0;
    {first_pair_o, second_pair_o, divisor_pair_o} = 48'h0;
    {wide_product_pair_o, wide_divisor_pair_o} = 64'h0;
  end

  // Register file takes a result only on its write pulse
  always @(posedge clock_i) begin
    if (first_pair_we_i) first_pair_o <= first_pair_i;
    if (divisor_pair_we_i) divisor_pair_o <= divisor_pair_i;
    if (wide_product_pair_we_i) wide_product_pair_o <= wide_product_pair_i;
    if (wide_divisor_pair_we_i) wide_divisor_pair_o <= wide_divisor_pair_i;
    if (first_pair_we_i | divisor_pair_we_i | wide_product_pair_we_i | wide_divisor_pair_we_i)
      n_writes <= n_writes + 1;
  end

  // Preload operands while the unit is idle
  task automatic load(input logic [15:0] a, b, d, input logic [31:0] wp, wd);
    @(posedge clock_i);
    first_pair_o <= a;
    second_pair_o <= b;
    divisor_pair_o <= d;
    wide_product_pair_o <= wp;
    wide_divisor_pair_o <= wd;
  endtask

  // One request; poke re-raises start in that busy cycle to test refusal.
  // No interrupt entry is modelled, so a divide is never broken into.
  task automatic issue(input logic [2:0] op, input logic ram, input int poke, output int lat);
    @(posedge clock_i);
    start_o <= 1'b1;
    op_o <= op;
    ram_fetch_o <= ram;
    @(posedge clock_i);
    start_o <= 1'b0;
    lat = 1;
    #1;
    // Bounded wait: a lost answer returns a count past any legal latency
    while (done_i !== 1'b1 && lat < 80) begin
      @(posedge clock_i);
      start_o <= (lat == poke);
      lat++;
      #1;
    end
    // One idle slot after every answer, the no-op behind a divide
    @(posedge clock_i);
    #1;
  endtask

  // Two byte multiplies on consecutive clocks, operands swapped in between
  task automatic byte_pair(input logic [15:0] a, b);
    @(posedge clock_i);
    first_pair_o <= a;
    op_o <= 3'h0;
    ram_fetch_o <= 1'b0;
    start_o <= 1'b1;
    @(posedge clock_i);
    first_pair_o <= b;
    @(posedge clock_i);
    start_o <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
endmodule // mdm_decoder_model
`default_nettype wire

/* mdm_divider.sv */
`default_nettype none
// Iterative restoring divider, two quotient bits per clock
module mdm_divider #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // Start with operands
  input  wire logic         load_i,
  input  wire logic [W-1:0] dividend_i,
  input  wire logic [W-1:0] divisor_i,
  input  wire logic [4:0]   iters_i,
  // Results, stable once iterations run out
  output logic      [W-1:0] quot_o,
  output logic      [W-1:0] rem_o
);
  logic [W-1:0] quot_reg, quot_next;   // Shifts dividend out, quotient in
  logic [W:0]   rem_reg, rem_next;     // Partial remainder, one guard bit
  logic [W-1:0] dsr_reg, dsr_next;     // Held divisor
  logic [4:0]   iter_reg, iter_next;   // Iterations still to run

  // Next-state: two restoring steps per clock. The loading clock already
  // runs the first step, so under flash fetch the result is ready one clock before write-back
  always_comb begin
    logic [W:0]   r;
    logic [W-1:0] q;
    logic [W-1:0] d;
    logic [4:0]   n;
    r          = rem_reg;
    q          = quot_reg;
    d          = dsr_reg;
    n          = iter_reg;
    quot_next  = quot_reg;
    rem_next   = rem_reg;
    dsr_next   = dsr_reg;
    iter_next  = iter_reg;
    if (load_i) begin
      // Fresh operands straight from the request
      r = '0;
      q = dividend_i;
      d = divisor_i;
      n = iters_i;
    end
    if (n != 5'h00) begin
      for (int s = 0; s < 2; s++) begin
        r = {r[W-1:0], q[W-1]};
        q = {q[W-2:0], 1'b0};
        // Zero divisor always subtracts: all-ones quotient, dividend back
        if (r >= {1'b0, d}) begin
          r    = r - {1'b0, d};
          q[0] = 1'b1;
        end
      end
      quot_next = q;
      rem_next  = r;
      dsr_next  = d;
      iter_next = n - 5'h01;
    end
  end

  // Registers only
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      quot_reg <= '0;
      rem_reg  <= '0;
      dsr_reg  <= '0;
      iter_reg <= 5'h00;
    end else begin
      quot_reg <= quot_next;
      rem_reg  <= rem_next;
      dsr_reg  <= dsr_next;
      iter_reg <= iter_next;
    end
  end

  assign quot_o = quot_reg;
  assign rem_o  = rem_reg[W-1:0];
endmodule : mdm_divider // mdm_divider
`default_nettype wire

/* mdm_pkg.sv */
`default_nettype none
package mdm_pkg;
  // Operation select presented by the decoder with a start request
  typedef enum logic [2:0] {
    MDM_OP_BYTE_MUL  = 3'h0, // byte_multiply
    MDM_OP_HMUL_U    = 3'h1, // unsigned_half_multiply
    MDM_OP_HMUL_S    = 3'h2, // signed_half_multiply
    MDM_OP_HDIV_U    = 3'h3, // unsigned_half_divide
    MDM_OP_WDIV_U    = 3'h4, // unsigned_word_divide
    MDM_OP_MAC_U     = 3'h5, // unsigned_multiply_accumulate
    MDM_OP_MAC_S     = 3'h6  // signed_multiply_accumulate
  } mdm_op_t;

  // Counter width covers the longest stretched latency (2*17+3)
  localparam int unsigned MDM_CNT_W = 6;

  // Latencies in CPU clocks when code runs from flash
  localparam logic [5:0] MDM_LAT_BYTE_MUL = 6'h01;
  localparam logic [5:0] MDM_LAT_HMUL     = 6'h02;
  localparam logic [5:0] MDM_LAT_HDIV     = 6'h09;
  localparam logic [5:0] MDM_LAT_WDIV     = 6'h11;
  localparam logic [5:0] MDM_LAT_MAC      = 6'h03;
  // Extra clocks added on top of the doubled count for RAM fetch
  localparam logic [5:0] MDM_RAM_EXTRA    = 6'h03;

  // Divider retires two quotient bits per clock
  localparam logic [4:0] MDM_DIV_ITER_H   = 5'h08;
  localparam logic [4:0] MDM_DIV_ITER_W   = 5'h10;

  // Aux carry is taken from the carry out of this bit of the sum
  localparam int unsigned MDM_AUX_CARRY_BIT = 3;

  // Accumulator reset value
  localparam logic [15:0] MDM_ACC_RST     = 16'h0000;
endpackage : mdm_pkg
`default_nettype wire

/* mdm_unit.sv */
`default_nettype none
// Behaviour
// - Byte multiply unsigned, one clock, into first_pair
// - Unsigned 16x16 multiply, two clocks, wide result
// - Signed 16x16 multiply, two clocks, wide result
// - 16-bit divide, nine clocks, quotient and remainder
// - 32-bit divide, seventeen clocks, quotient and remainder
// - Accumulate product, three clocks, sets both carries
// - Accumulator built from upper and lower halves
// - Listed counts hold for internal data accesses
// - RAM fetch stretches count to 2N+3
module mdm_unit (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Request from the decoder
  input  wire logic        start_i,
  input  wire logic [2:0]  op_i,
  input  wire logic        ram_fetch_i,
  input  wire logic [15:0] first_pair_i,
  input  wire logic [15:0] second_pair_i,
  input  wire logic [15:0] divisor_pair_i,
  input  wire logic [31:0] wide_product_pair_i,
  input  wire logic [31:0] wide_divisor_pair_i,
  // Handshake
  output logic             busy_o,
  output logic             done_o,
  // Register-file write-back
  output logic             first_pair_we_o,
  output logic [15:0]      first_pair_o,
  output logic             divisor_pair_we_o,
  output logic [15:0]      divisor_pair_o,
  output logic             wide_product_pair_we_o,
  output logic [31:0]      wide_product_pair_o,
  output logic             wide_divisor_pair_we_o,
  output logic [31:0]      wide_divisor_pair_o,
  // Accumulator and flags
  output logic [15:0]      accum_upper_o,
  output logic [15:0]      accum_lower_o,
  output logic             flags_we_o,
  output logic             aux_carry_flag_o,
  output logic             carry_flag_o
);
  // One-hot sequencer states
  typedef enum logic [1:0] {
    MDM_ST_IDLE = 2'h1,
    MDM_ST_RUN  = 2'h2
  } mdm_state_t;

  mdm_state_t      state_reg, state_next;     // Sequencer
  logic [5:0]      cnt_reg, cnt_next;         // Clocks left before write-back
  mdm_pkg::mdm_op_t op_reg, op_next;          // Latched operation
  logic [15:0]     a_reg, a_next;             // Latched first_pair
  logic [15:0]     b_reg, b_next;             // Latched second_pair
  logic [15:0]     acc_hi_reg, acc_hi_next;   // accum_upper
  logic [15:0]     acc_lo_reg, acc_lo_next;   // accum_lower
  logic            done_reg, done_next;
  logic            fp_we_reg, fp_we_next;
  logic            dp_we_reg, dp_we_next;
  logic            wp_we_reg, wp_we_next;
  logic            wd_we_reg, wd_we_next;
  logic            fl_we_reg, fl_we_next;
  logic [15:0]     fp_reg, fp_next;
  logic [15:0]     dp_reg, dp_next;
  logic [31:0]     wp_reg, wp_next;
  logic [31:0]     wd_reg, wd_next;
  logic            auxc_reg, auxc_next;
  logic            carry_reg, carry_next;

  // Datapath helpers
  logic            accept;                    // Request taken this cycle
  logic            is_div_h;                  // op_i selects 16-bit divide
  logic [5:0]      lat_base;                  // Listed latency of op_i
  logic [5:0]      lat_eff;                   // Latency after fetch stretch
  logic [31:0]     prod_u, prod_s, prod_sel;  // 16x16 products
  logic [32:0]     mac_sum;                   // Accumulate with carry out
  logic [4:0]      nib_sum;                   // Low nibble for aux carry
  logic [31:0]     div_q, div_r;              // Divider results
  logic [31:0]     div_dividend, div_divisor;
  logic [4:0]      div_iters;

  assign accept   = start_i && (state_reg == MDM_ST_IDLE);
  assign is_div_h = (op_i == 3'(mdm_pkg::MDM_OP_HDIV_U));

  // Listed latency per opcode; no data is accessed, so these hold
  always_comb begin
    case (op_i)
      3'(mdm_pkg::MDM_OP_BYTE_MUL): lat_base = mdm_pkg::MDM_LAT_BYTE_MUL;
      3'(mdm_pkg::MDM_OP_HMUL_U),
      3'(mdm_pkg::MDM_OP_HMUL_S):   lat_base = mdm_pkg::MDM_LAT_HMUL;
      3'(mdm_pkg::MDM_OP_HDIV_U):   lat_base = mdm_pkg::MDM_LAT_HDIV;
      3'(mdm_pkg::MDM_OP_WDIV_U):   lat_base = mdm_pkg::MDM_LAT_WDIV;
      default:                      lat_base = mdm_pkg::MDM_LAT_MAC;
    endcase
  end
  // Worst-case stretch under RAM fetch; the divider finishes early and waits
  assign lat_eff = ram_fetch_i ? 6'((lat_base << 1) + mdm_pkg::MDM_RAM_EXTRA)
                               : lat_base;

  // Products from latched operands
  assign prod_u   = a_reg * b_reg;
  // Operands sign-extended first so the product is formed at full width
  assign prod_s   = $signed({{16{a_reg[15]}}, a_reg}) * $signed({{16{b_reg[15]}}, b_reg});
  assign prod_sel = (op_reg == mdm_pkg::MDM_OP_MAC_S ||
                     op_reg == mdm_pkg::MDM_OP_HMUL_S) ? prod_s : prod_u;
  // Flags: carry out of bit 31 and out of the low nibble of the sum
  assign mac_sum  = {1'b0, acc_hi_reg, acc_lo_reg} + {1'b0, prod_sel};
  assign nib_sum  = {1'b0, acc_lo_reg[mdm_pkg::MDM_AUX_CARRY_BIT:0]} + {1'b0, prod_sel[3:0]};

  // 16-bit divide sits in the top half so eight iterations suffice
  assign div_dividend = is_div_h ? {first_pair_i, 16'h0000} : wide_product_pair_i;
  assign div_divisor  = is_div_h ? {16'h0000, divisor_pair_i} : wide_divisor_pair_i;
  assign div_iters    = is_div_h ? mdm_pkg::MDM_DIV_ITER_H : mdm_pkg::MDM_DIV_ITER_W;

  mdm_divider #(
    .W (32)
  ) u_div (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .load_i     (accept && (is_div_h || op_i == 3'(mdm_pkg::MDM_OP_WDIV_U))),
    .dividend_i (div_dividend),
    .divisor_i  (div_divisor),
    .iters_i    (div_iters),
    .quot_o     (div_q),
    .rem_o      (div_r)
  );

  // Sequencer and write-back next values
  always_comb begin
    logic fin;
    fin         = 1'b0;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    op_next     = op_reg;
    a_next      = a_reg;
    b_next      = b_reg;
    acc_hi_next = acc_hi_reg;
    acc_lo_next = acc_lo_reg;
    fp_next     = fp_reg;
    dp_next     = dp_reg;
    wp_next     = wp_reg;
    wd_next     = wd_reg;
    auxc_next   = auxc_reg;
    carry_next  = carry_reg;
    done_next   = 1'b0;
    fp_we_next  = 1'b0;
    dp_we_next  = 1'b0;
    wp_we_next  = 1'b0;
    wd_we_next  = 1'b0;
    fl_we_next  = 1'b0;
    case (state_reg)
      MDM_ST_IDLE: begin
        if (accept) begin
          op_next = mdm_pkg::mdm_op_t'(op_i);
          a_next  = first_pair_i;
          b_next  = second_pair_i;
          if (lat_eff == 6'h01) begin
            // Single-clock byte multiply finishes at the accepting edge
            fp_next    = 16'(first_pair_i[15:8]) * 16'(first_pair_i[7:0]);
            fp_we_next = 1'b1;
            done_next  = 1'b1;
          end else begin
            cnt_next   = lat_eff - 6'h01;
            state_next = MDM_ST_RUN;
          end
        end
      end
      MDM_ST_RUN: begin
        cnt_next = cnt_reg - 6'h01;
        fin      = (cnt_reg == 6'h01);
        // Nothing is written before the last clock of the latency
        if (fin) begin
          state_next = MDM_ST_IDLE;
          done_next  = 1'b1;
          case (op_reg)
            mdm_pkg::MDM_OP_BYTE_MUL: begin
              fp_next    = 16'(a_reg[15:8]) * 16'(a_reg[7:0]);
              fp_we_next = 1'b1;
            end
            mdm_pkg::MDM_OP_HMUL_U,
            mdm_pkg::MDM_OP_HMUL_S: begin
              wp_next    = prod_sel;
              wp_we_next = 1'b1;
            end
            mdm_pkg::MDM_OP_HDIV_U: begin
              fp_next    = div_q[15:0];
              dp_next    = div_r[15:0];
              fp_we_next = 1'b1;
              dp_we_next = 1'b1;
            end
            mdm_pkg::MDM_OP_WDIV_U: begin
              wp_next    = div_q;
              wd_next    = div_r;
              wp_we_next = 1'b1;
              wd_we_next = 1'b1;
            end
            mdm_pkg::MDM_OP_MAC_U,
            mdm_pkg::MDM_OP_MAC_S: begin
              // No zero flag leaves this unit for accumulates
              acc_hi_next = mac_sum[31:16];
              acc_lo_next = mac_sum[15:0];
              carry_next  = mac_sum[32];
              auxc_next   = nib_sum[4];
              fl_we_next  = 1'b1;
            end
            default: begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        state_next = MDM_ST_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg  <= MDM_ST_IDLE;
      cnt_reg    <= 6'h00;
      op_reg     <= mdm_pkg::MDM_OP_BYTE_MUL;
      a_reg      <= 16'h0000;
      b_reg      <= 16'h0000;
      acc_hi_reg <= mdm_pkg::MDM_ACC_RST;
      acc_lo_reg <= mdm_pkg::MDM_ACC_RST;
      done_reg   <= 1'b0;
      fp_we_reg  <= 1'b0;
      dp_we_reg  <= 1'b0;
      wp_we_reg  <= 1'b0;
      wd_we_reg  <= 1'b0;
      fl_we_reg  <= 1'b0;
      fp_reg     <= 16'h0000;
      dp_reg     <= 16'h0000;
      wp_reg     <= 32'h0000_0000;
      wd_reg     <= 32'h0000_0000;
      auxc_reg   <= 1'b0;
      carry_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      op_reg     <= op_next;
      a_reg      <= a_next;
      b_reg      <= b_next;
      acc_hi_reg <= acc_hi_next;
      acc_lo_reg <= acc_lo_next;
      done_reg   <= done_next;
      fp_we_reg  <= fp_we_next;
      dp_we_reg  <= dp_we_next;
      wp_we_reg  <= wp_we_next;
      wd_we_reg  <= wd_we_next;
      fl_we_reg  <= fl_we_next;
      fp_reg     <= fp_next;
      dp_reg     <= dp_next;
      wp_reg     <= wp_next;
      wd_reg     <= wd_next;
      auxc_reg   <= auxc_next;
      carry_reg  <= carry_next;
    end
  end

  // Output drive; busy gates new requests, and a request raised while busy is dropped
  assign busy_o                 = (state_reg == MDM_ST_RUN);
  assign done_o                 = done_reg;
  assign first_pair_we_o        = fp_we_reg;
  assign first_pair_o           = fp_reg;
  assign divisor_pair_we_o      = dp_we_reg;
  assign divisor_pair_o         = dp_reg;
  assign wide_product_pair_we_o = wp_we_reg;
  assign wide_product_pair_o    = wp_reg;
  assign wide_divisor_pair_we_o = wd_we_reg;
  assign wide_divisor_pair_o    = wd_reg;
  assign accum_upper_o          = acc_hi_reg;
  assign accum_lower_o          = acc_lo_reg;
  assign flags_we_o             = fl_we_reg;
  assign aux_carry_flag_o       = auxc_reg;
  assign carry_flag_o           = carry_reg;

  // Checks
  logic        fl_start;   // Start from flash
  logic [31:0] chk_prod_s; // Signed product of request operands
  assign fl_start   = accept && !ram_fetch_i;
  assign chk_prod_s = $signed({{16{first_pair_i[15]}}, first_pair_i}) *
                      $signed({{16{second_pair_i[15]}}, second_pair_i});

  sequence s_quiet(int n);
    !done_o [*1];
  endsequence

  byte_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h0 |=> done_o && first_pair_we_o && !busy_o)
    else $error("byte multiply latency wrong");
  hmul_sign_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h2 |=> !done_o
    ##1 (done_o && wide_product_pair_we_o && wide_product_pair_o == $past(chk_prod_s, 2)))
    else $error("signed half multiply result or timing wrong");
  hmul_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h1 |-> ##2 (done_o && wide_product_pair_we_o))
    else $error("unsigned half multiply latency wrong");
  hdiv_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h3 |-> ##9 (done_o && first_pair_we_o && divisor_pair_we_o))
    else $error("half divide latency wrong");
  wdiv_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h4 |-> ##17 (done_o && wide_divisor_pair_we_o))
    else $error("word divide latency wrong");
  mac_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fl_start && op_i == 3'h5 |-> ##3 (done_o && flags_we_o && !first_pair_we_o))
    else $error("accumulate latency wrong");
  accum_pair_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    flags_we_o |-> {accum_upper_o, accum_lower_o} ==
                   32'({$past(accum_upper_o), $past(accum_lower_o)} + prod_sel))
    else $error("accumulator halves not updated together");
  ram_lat_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    accept && ram_fetch_i && op_i == 3'h0 |=> s_quiet(1) ##1 !done_o [*3] ##1 done_o)
    else $error("stretched latency wrong");
  no_early_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    busy_o && cnt_reg > 6'h01 |=> !(first_pair_we_o || wide_product_pair_we_o || flags_we_o ||
                                    divisor_pair_we_o || wide_divisor_pair_we_o))
    else $error("result written before latency elapsed");
endmodule : mdm_unit // mdm_unit
`default_nettype wire

/* mdm_unit_bench.sv */
`default_nettype none
// Self-checking bench for the multiply, divide and accumulate unit
module mdm_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock_i;
  logic        rst_b_i;
  wire  logic        start, ram, busy, done, fp_we, dp_we, wp_we, wd_we, fl_we, auxc, carry;
  wire  logic [2:0]  op;
  wire  logic [15:0] fp, sp, dp, fp_o, dp_o, acc_hi, acc_lo;
  wire  logic [31:0] wp, wd, wp_o, wd_o;
  int          fails = 0;
  int          n_checks = 0;

  // CPU clock, 10 ns period
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  mdm_unit dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start), .op_i(op), .ram_fetch_i(ram),
    .first_pair_i(fp), .second_pair_i(sp), .divisor_pair_i(dp), .wide_product_pair_i(wp),
    .wide_divisor_pair_i(wd), .busy_o(busy), .done_o(done), .first_pair_we_o(fp_we),
    .first_pair_o(fp_o), .divisor_pair_we_o(dp_we), .divisor_pair_o(dp_o),
    .wide_product_pair_we_o(wp_we), .wide_product_pair_o(wp_o),
    .wide_divisor_pair_we_o(wd_we), .wide_divisor_pair_o(wd_o), .accum_upper_o(acc_hi),
    .accum_lower_o(acc_lo), .flags_we_o(fl_we), .aux_carry_flag_o(auxc), .carry_flag_o(carry));

  mdm_decoder_model model (
    .clock_i(clock_i), .start_o(start), .op_o(op), .ram_fetch_o(ram), .first_pair_o(fp),
    .second_pair_o(sp), .divisor_pair_o(dp), .wide_product_pair_o(wp),
    .wide_divisor_pair_o(wd), .done_i(done), .first_pair_we_i(fp_we), .first_pair_i(fp_o),
    .divisor_pair_we_i(dp_we), .divisor_pair_i(dp_o), .wide_product_pair_we_i(wp_we),
    .wide_product_pair_i(wp_o), .wide_divisor_pair_we_i(wd_we), .wide_divisor_pair_i(wd_o));

  // Single exit point for the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Value compare, four-state so an unknown never matches
  task automatic check_val(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Latency compare; a count past the bound means the answer never came
  task automatic check_lat(input int got, exp);
    n_checks++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH t=%0t latency got %0d exp %0d", $time, got, exp);
    end
    if (got >= 80) give_verdict();
  endtask

  // Outputs sit at zero straight after reset
  task automatic t_reset();
    check_val({busy, done, fl_we, auxc, carry, fp_o}, 32'h0, "idle outputs");
    check_val({acc_hi, acc_lo}, 32'h0, "accumulator at reset");
  endtask

  // Every opcode, flash fetch then RAM fetch worst case
  task automatic t_latency();
    int nl[7] = '{1, 2, 2, 9, 17, 3, 3};
    int lat;
    for (int o = 0; o < 7; o++) begin
      for (int r = 0; r < 2; r++) begin
        model.issue(3'(o), r[0], 0, lat);
        check_lat(lat, r ? 2 * nl[o] + 3 : nl[o]);
      end
    end
  endtask

  // Multiplies, with a sign bit set to tell signed from unsigned
  task automatic t_mul();
    logic [31:0] s;
    int lat;
    model.load(16'h8003, 16'hFFFD, 16'h0, 32'h0, 32'h0);
    model.issue(3'h1, 1'b0, 0, lat);
    check_lat(lat, 2);
    check_val(wp, 32'h8003 * 32'hFFFD, "unsigned product");
    s = $signed(16'h8003) * $signed(16'hFFFD);
    model.load(16'h8003, 16'hFFFD, 16'h0, 32'h0, 32'h0);
    model.issue(3'h2, 1'b0, 0, lat);
    check_lat(lat, 2);
    check_val(wp, s, "signed product");
    // Back to back: only the second byte product may be left behind
    model.byte_pair(16'h1234, 16'hFFFE);
    check_val({16'h0, fp}, 32'h00FF * 32'h00FE, "byte product");
  endtask

  // Divides, including divide by zero and a refused request while busy
  task automatic t_div();
    logic [15:0] ha[2] = '{16'h1234, 16'hBEEF};
    logic [15:0] hd[2] = '{16'h0007, 16'h0000};
    logic [31:0] wa[2] = '{32'h89ABCDEF, 32'h00FF00FF};
    logic [31:0] wdv[2] = '{32'h00012345, 32'h00000000};
    int lat;
    int w0;
    for (int i = 0; i < 2; i++) begin
      model.load(ha[i], 16'h0, hd[i], wa[i], wdv[i]);
      w0 = model.n_writes;
      model.issue(3'h3, 1'b0, 3, lat);
      check_lat(lat, 9);
      check_val(model.n_writes - w0, 32'h1, "one write slot");
      check_val({fp, dp}, hd[i] == 0 ? {16'hFFFF, ha[i]} : {ha[i] / hd[i], ha[i] % hd[i]},
                "half quotient and remainder");
      model.issue(3'h4, 1'b0, 5, lat);
      check_lat(lat, 17);
      check_val(wp, wdv[i] == 0 ? 32'hFFFFFFFF : wa[i] / wdv[i], "word quotient");
      check_val(wd, wdv[i] == 0 ? wa[i] : wa[i] % wdv[i], "word remainder");
    end
  endtask

  // Accumulate chain that sets carry, then aux carry with a signed product
  task automatic t_mac();
    logic [15:0] ma[3] = '{16'hFFFF, 16'hFFFF, 16'hFFFF};
    logic [15:0] mb[3] = '{16'hFFFF, 16'hFFFF, 16'h0002};
    logic [31:0] acc;
    logic [31:0] prod;
    logic [32:0] sum;
    logic [4:0]  nib;
    int          lat;
    acc = 32'h0;
    for (int i = 0; i < 3; i++) begin
      model.load(ma[i], mb[i], 16'h0, 32'h0, 32'h0);
      if (i == 2) prod = $signed(ma[i]) * $signed(mb[i]);
      else prod = ma[i] * mb[i];
      sum = {1'b0, acc} + {1'b0, prod};
      nib = {1'b0, acc[3:0]} + {1'b0, prod[3:0]};
      acc = sum[31:0];
      model.issue(i == 2 ? 3'h6 : 3'h5, 1'b0, 0, lat);
      check_lat(lat, 3);
      check_val({acc_hi, acc_lo}, acc, "accumulator halves");
      check_val({30'h0, auxc, carry}, {30'h0, nib[4], sum[32]}, "aux carry and carry");
    end
  endtask

  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    #1;
    t_reset();
    t_latency();
    t_mul();
    t_div();
    t_mac();
    give_verdict();
  end
endmodule // mdm_unit_bench
`default_nettype wire
